/* rtl/pscr_pkg.sv */
package pscr_pkg;
    // widths of the serial words, their fields and the counters
    localparam int FREQ_W = 20;
    localparam int ENH_W = 8;
    localparam int REF_W = 6;
    localparam int MAIN_W = 9;
    localparam int SWAL_W = 4;
    localparam int DIV_W = 13;
    localparam int CNT_W = 5;

    // frequency word field bases, in shift order
    localparam int FW_REF_HI = 0;
    localparam int FW_MAIN_HI = 2;
    localparam int FW_BYPASS = 4;
    localparam int FW_MAIN_LO = 5;
    localparam int FW_REF_LO = 12;
    localparam int FW_SWAL = 16;

    // test mode control bits
    localparam int TM_MIRROR_OUT = 1;
    localparam int TM_MAIN_OUT = 2;
    localparam int TM_POWER_DOWN = 3;
    localparam int TM_CNT_LOAD = 4;
    localparam int TM_MOD_OUT = 5;
    localparam int TM_REF_OUT = 6;
    localparam logic [ENH_W-1:0] TM_USED_MASK = 8'h7E;

    // prescaler moduli
    localparam logic [DIV_W-1:0] PRE_LOW = 13'h000A;
    localparam logic [DIV_W-1:0] PRE_HIGH = 13'h000B;

    // synchroniser lanes in the device
    localparam int LN_SCLK = 0;
    localparam int LN_DATA = 1;
    localparam int LN_COPY = 2;
    localparam int LN_XLAT = 3;
    localparam int LN_ROUTE = 4;
    localparam int LN_MODULUS_CHOICE = 5;
    localparam int LN_CHOICE = 6;
    localparam int LN_GATE = 7;
    localparam int LN_UP = 8;
    localparam int LN_DN = 9;
    localparam int N_LANES = 10;
    localparam logic [N_LANES-1:0] LANE_RST = 10'h380;

    // host serial clock timing
    localparam int CORE_CLK_MHZ = 100;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;

    // host apb map
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_DATA_OFS = 8'h04;
    localparam logic [7:0] HOST_PINS_OFS = 8'h08;
    localparam logic [7:0] HOST_STAT_OFS = 8'h0C;
    localparam logic [7:0] HOST_CAPT_OFS = 8'h10;
    localparam int PIN_MODULUS_CHOICE = 0;
    localparam int PIN_CHOICE = 1;
    localparam int PIN_GATE_N = 2;
    localparam int PIN_ROUTE = 3;
    localparam int PIN_COPY = 4;
    localparam int PIN_W = 5;
    localparam logic [PIN_W-1:0] PINS_RST = 5'h04;

    typedef enum logic [1:0] {
        PSCR_OP_PRIMARY = 2'h0,
        PSCR_OP_TESTMODE = 2'h1,
        PSCR_OP_MIRROR = 2'h2,
        PSCR_OP_COPY = 2'h3
    } pscr_op_e;

    typedef enum logic [2:0] {
        PSCR_SRC_PRIMARY = 3'h1,
        PSCR_SRC_SECONDARY = 3'h2,
        PSCR_SRC_MIRROR = 3'h4
    } pscr_src_e;

    // field extraction, shift order is reversed against the field order
    function automatic logic [REF_W-1:0] fw_ref(input logic [FREQ_W-1:0] w);
        logic [REF_W-1:0] r;
        r = '0;
        for (int i = 0; i < 2; i++) r[REF_W-1-i] = w[FW_REF_HI+i];
        for (int i = 0; i < 4; i++) r[3-i] = w[FW_REF_LO+i];
        return r;
    endfunction

    function automatic logic [MAIN_W-1:0] fw_main(input logic [FREQ_W-1:0] w);
        logic [MAIN_W-1:0] m;
        m = '0;
        for (int i = 0; i < 2; i++) m[MAIN_W-1-i] = w[FW_MAIN_HI+i];
        for (int i = 0; i < 7; i++) m[6-i] = w[FW_MAIN_LO+i];
        return m;
    endfunction

    function automatic logic [SWAL_W-1:0] fw_swal(input logic [FREQ_W-1:0] w);
        logic [SWAL_W-1:0] a;
        a = '0;
        for (int i = 0; i < SWAL_W; i++) a[SWAL_W-1-i] = w[FW_SWAL+i];
        return a;
    endfunction
endpackage

/* rtl/pscr_link_if.sv */
`timescale 1ns/1ps
interface pscr_link_if;
    logic ser_clk;
    logic ser_data;
    logic copy_strobe;
    logic extra_latch;
    logic route_select;
    logic memory_select;
    logic freq_reg_choice;
    logic extra_modes_gate_n;
    logic readout;

    modport host (
        output ser_clk, ser_data, copy_strobe, extra_latch, route_select,
        output memory_select, freq_reg_choice, extra_modes_gate_n,
        input readout
    );
    modport dev (
        input ser_clk, ser_data, copy_strobe, extra_latch, route_select,
        input memory_select, freq_reg_choice, extra_modes_gate_n,
        output readout
    );
endinterface

/* rtl/pscr_device.sv */
// Summary of operation
// [R1] data sampled on each serial clock rise
// [R2] words enter least significant bit first
// [R3] strobes and route pick shift destination
// [R4] three independent twenty-bit frequency registers
// [R5] frequency word field layout in shift order
// [R6] primary feeds counters live while shifting
// [R7] copy strobe rise copies primary to secondary
// [R8] memory select and choice pick source
// [R9] mirror loads from store on edges
// [R10] only stored data drives from mirror
// [R11] mirror readout shifts out on clock
// [R12] eight-bit test word, reserved bits zero
// [R13] test bit acts only with gate low
// [R14] host sets one readout bit only
// [R15] test word latched on latch strobe fall
// [R16] gate high disables all test bits
// [R17] power down stops all but interface; here the lock outputs keep following the pump pulses
// [R18] counter load takes values continuously
// [R19] readout carries divider or modulus signals
// [R20] lock node nand, indicator its inverse
// [R21] store write takes all mirror bits
// [R22] bypass divides by main counter alone
// [R23] counters reload at end of cycle
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module pscr_device
    import pscr_pkg::*;
#(
    parameter logic [FREQ_W-1:0] NV_INIT = 20'h00000
) (
    input wire logic core_clk,
    input wire logic resetn,
    pscr_link_if.dev link,
    input wire logic ref_tick,
    input wire logic vco_tick,
    input wire logic nv_write_pulse,
    input wire logic nv_erase_pulse,
    input wire logic pump_up_pulse_n,
    input wire logic pump_down_pulse_n,
    output logic [REF_W-1:0] ref_value,
    output logic [MAIN_W-1:0] main_value,
    output logic [SWAL_W-1:0] swallow_value,
    output logic prescaler_bypass,
    output logic power_down,
    output logic ref_out,
    output logic main_out,
    output logic modulus_choice,
    output logic lock_integrate_node,
    output logic lock_indicator
);
    logic [N_LANES-1:0] lane_raw;
    logic [N_LANES-1:0] meta_ff;
    logic [N_LANES-1:0] sync_ff;
    logic [N_LANES-1:0] prev_ff;
    logic [FREQ_W-1:0] primary_ff;
    logic [FREQ_W-1:0] secondary_ff;
    logic [FREQ_W-1:0] mirror_ff;
    logic [FREQ_W-1:0] nv_ff;
    logic [ENH_W-1:0] tm_shift_ff;
    logic [ENH_W-1:0] tm_ff;
    pscr_src_e src_ff;
    logic [FREQ_W-1:0] prog_ff;
    logic [REF_W-1:0] ref_cnt_ff;
    logic [DIV_W-1:0] main_cnt_ff;
    logic ref_out_ff, main_out_ff, mod_ff, readout_ff, integ_ff, lock_ff, pd_ff;

    assign lane_raw = {pump_down_pulse_n, pump_up_pulse_n, link.extra_modes_gate_n, link.freq_reg_choice,
                       link.memory_select, link.route_select, link.extra_latch, link.copy_strobe,
                       link.ser_data, link.ser_clk};

    // every link pin is asynchronous to core_clk: two flops, then edge history
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= LANE_RST;
            sync_ff <= LANE_RST;
            prev_ff <= LANE_RST;
        end else begin
            meta_ff <= lane_raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    wire sclk_rise = sync_ff[LN_SCLK] & ~prev_ff[LN_SCLK];
    wire copy_lvl = sync_ff[LN_COPY];
    wire copy_rise = copy_lvl & ~prev_ff[LN_COPY];
    wire xlat_fall = ~sync_ff[LN_XLAT] & prev_ff[LN_XLAT];
    wire route_lvl = sync_ff[LN_ROUTE];
    wire route_fall = ~route_lvl & prev_ff[LN_ROUTE];
    wire modulus_choice_lvl = sync_ff[LN_MODULUS_CHOICE];
    wire modulus_choice_rise = modulus_choice_lvl & ~prev_ff[LN_MODULUS_CHOICE];
    wire sdata = sync_ff[LN_DATA];

    // destination decode, only with copy strobe low
    wire to_primary = ~copy_lvl & ~sync_ff[LN_XLAT] & ~route_lvl; // [R3]
    wire to_testmode = ~copy_lvl & sync_ff[LN_XLAT] & ~route_lvl; // [R3]
    wire to_mirror = ~copy_lvl & route_lvl; // [R3]

    // store copy into mirror: memory select rise with route low, or route fall with memory select high
    wire nv_copy = (modulus_choice_rise & ~route_lvl) | (route_fall & modulus_choice_lvl); // [R9]
    wire nv_prog = copy_lvl & route_lvl & ~modulus_choice_lvl & nv_write_pulse;
    wire nv_erase = copy_lvl & route_lvl & modulus_choice_lvl & nv_erase_pulse;

    // test bits gated by the active-low gate pin, reserved bits never act
    wire [ENH_W-1:0] tm_act = tm_ff & TM_USED_MASK & {ENH_W{~sync_ff[LN_GATE]}}; // [R12] [R13] [R16]
    wire pd_act = tm_act[TM_POWER_DOWN];

    // primary, secondary and test shift registers, lsb enters first and ends at bit 0
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            primary_ff <= '0;
            secondary_ff <= '0;
            tm_shift_ff <= '0;
            tm_ff <= '0;
        end else begin
            if (sclk_rise && to_primary) primary_ff <= {sdata, primary_ff[FREQ_W-1:1]}; // [R1] [R2]
            if (sclk_rise && to_testmode) tm_shift_ff <= {sdata, tm_shift_ff[ENH_W-1:1]}; // [R1] [R2]
            if (copy_rise) secondary_ff <= primary_ff; // [R7]
            if (xlat_fall) tm_ff <= tm_shift_ff; // [R15]
        end
    end

    // mirror register and the non-volatile store behind it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mirror_ff <= '0;
            nv_ff <= NV_INIT;
        end else begin
            if (nv_copy) begin
                mirror_ff <= nv_ff; // [R9]
            end else if (sclk_rise && to_mirror) begin
                mirror_ff <= {sdata, mirror_ff[FREQ_W-1:1]}; // [R1] [R2] [R11]
            end
            // a write ands into the store, so an erase to ones must come first
            if (nv_erase) begin
                nv_ff <= '1;
            end else if (nv_prog) begin
                nv_ff <= nv_ff & mirror_ff; // [R21]
            end
        end
    end

    // source choice is only decoded with route low; while route is high the
    // last choice stands, so serially shifted mirror data never steers counters
    wire pscr_src_e src_nxt = modulus_choice_lvl ? PSCR_SRC_MIRROR :
                              (sync_ff[LN_CHOICE] ? PSCR_SRC_PRIMARY : PSCR_SRC_SECONDARY); // [R8]
    wire [FREQ_W-1:0] sel_word = (src_ff == PSCR_SRC_PRIMARY) ? primary_ff : // [R6]
                                 (src_ff == PSCR_SRC_SECONDARY) ? secondary_ff : mirror_ff; // [R4] [R10]

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) src_ff <= PSCR_SRC_SECONDARY;
        else if (!route_lvl) src_ff <= src_nxt; // [R10]
    end

    // programmed values in use, split from the selected word
    wire [REF_W-1:0] p_ref = fw_ref(prog_ff); // [R5]
    wire [MAIN_W-1:0] p_main = fw_main(prog_ff); // [R5]
    wire [SWAL_W-1:0] p_swal = fw_swal(prog_ff); // [R5]
    wire p_bypass = prog_ff[FW_BYPASS]; // [R5]

    // divide length minus one: bypass uses main alone, else 10*(m+1)+a-1
    wire [DIV_W-1:0] main_m = DIV_W'(p_main);
    wire [DIV_W-1:0] div_last = p_bypass ? main_m : // [R22]
                                DIV_W'(PRE_LOW * main_m + PRE_LOW - 13'h0001 + DIV_W'(p_swal));
    wire [DIV_W-1:0] elapsed = div_last - main_cnt_ff;
    wire in_high_mod = ~p_bypass & (elapsed < DIV_W'(PRE_HIGH * DIV_W'(p_swal))); // [R22]

    wire main_end = vco_tick & (main_cnt_ff == '0);
    wire ref_end = ref_tick & (ref_cnt_ff == '0);
    wire mirror_live = (route_lvl | prev_ff[LN_ROUTE]) & (src_ff == PSCR_SRC_MIRROR);
    wire take_prog = (main_end | tm_act[TM_CNT_LOAD]) & ~mirror_live; // [R10] [R18] [R23]

    // counters run only when not powered down; they reload at the end of each cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prog_ff <= '0;
            ref_cnt_ff <= '0;
            main_cnt_ff <= '0;
            ref_out_ff <= 1'b0;
            main_out_ff <= 1'b0;
            mod_ff <= 1'b0;
        end else if (pd_act) begin
            ref_cnt_ff <= p_ref; // [R17]
            main_cnt_ff <= div_last; // [R17]
            ref_out_ff <= 1'b0;
            main_out_ff <= 1'b0;
            mod_ff <= 1'b0;
        end else begin
            if (take_prog) prog_ff <= sel_word; // [R18] [R23]
            if (ref_end) ref_cnt_ff <= p_ref;
            else if (ref_tick) ref_cnt_ff <= ref_cnt_ff - 6'h01;
            if (main_end) main_cnt_ff <= div_last; // [R23]
            else if (vco_tick) main_cnt_ff <= main_cnt_ff - 13'h0001;
            ref_out_ff <= ref_end;
            main_out_ff <= main_end;
            mod_ff <= in_high_mod;
        end
    end

    // readout mux; the host keeps at most one source bit set
    wire readout_nxt = (tm_act[TM_MIRROR_OUT] & mirror_ff[0]) | // [R11] [R14]
                       (tm_act[TM_MAIN_OUT] & main_out_ff) | // [R19]
                       (tm_act[TM_MOD_OUT] & mod_ff) | // [R19]
                       (tm_act[TM_REF_OUT] & ref_out_ff); // [R19]

    // lock outputs from the synchronised pump pulses
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            readout_ff <= 1'b0;
            integ_ff <= 1'b0;
            lock_ff <= 1'b1;
            pd_ff <= 1'b0;
        end else begin
            pd_ff <= pd_act; // [R17]
            readout_ff <= readout_nxt;
            integ_ff <= ~(sync_ff[LN_UP] & sync_ff[LN_DN]); // [R20]
            lock_ff <= sync_ff[LN_UP] & sync_ff[LN_DN]; // [R20]
        end
    end

    assign link.readout = readout_ff;
    assign ref_value = p_ref;
    assign main_value = p_main;
    assign swallow_value = p_swal;
    assign prescaler_bypass = p_bypass;
    assign power_down = pd_ff;
    assign ref_out = ref_out_ff;
    assign main_out = main_out_ff;
    assign modulus_choice = mod_ff;
    assign lock_integrate_node = integ_ff;
    assign lock_indicator = lock_ff;
endmodule

/* rtl/pscr_host.sv */
`timescale 1ns/1ps
module pscr_host
    import pscr_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pscr_link_if.host link
);
    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_LOW = 5'h02,
        HS_HIGH = 5'h04,
        HS_DONE = 5'h08,
        HS_COPY = 5'h10
    } pscr_hstate_e;

    pscr_hstate_e st_ff;
    logic [FREQ_W-1:0] data_ff;
    logic [FREQ_W-1:0] capt_ff;
    logic [PIN_W-1:0] pins_ff;
    pscr_op_e op_ff;
    logic [CNT_W-1:0] bit_ff;
    logic [7:0] tmr_ff;
    logic sclk_ff, sdat_ff, xlat_ff, route_ff, copy_ff;
    logic rd_meta_ff, rd_sync_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;

    // apb decode: answer on the second access cycle
    wire acc = psel & penable & ~pready_ff;
    wire done_acc = psel & penable & pready_ff;
    wire hit_cmd = paddr == HOST_CMD_OFS;
    wire hit_data = paddr == HOST_DATA_OFS;
    wire hit_pins = paddr == HOST_PINS_OFS;
    wire hit_stat = paddr == HOST_STAT_OFS;
    wire hit_capt = paddr == HOST_CAPT_OFS;
    wire hit_any = hit_cmd | hit_data | hit_pins | hit_stat | hit_capt;
    wire busy = st_ff != HS_IDLE;
    wire go = done_acc & pwrite & hit_cmd & ~pslverr_ff & ~busy;
    wire [31:0] rd_mux = hit_data ? 32'(data_ff) : hit_pins ? 32'(pins_ff) :
                         hit_stat ? 32'(busy) : hit_capt ? 32'(capt_ff) : 32'h00000000;
    wire last_bit = bit_ff == CNT_W'((op_ff == PSCR_OP_TESTMODE) ? ENH_W - 1 : FREQ_W - 1);
    wire tmr_end = tmr_ff == 8'(HALF_CYC - 1);

    // bus slave, a command while busy is answered with an error
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            data_ff <= '0;
            pins_ff <= PINS_RST;
        end else begin
            pready_ff <= acc;
            pslverr_ff <= acc & (~hit_any | (pwrite & (hit_stat | hit_capt | (hit_cmd & busy))));
            prdata_ff <= acc & ~pwrite ? rd_mux : 32'h00000000;
            if (done_acc && pwrite && hit_data && !busy) data_ff <= pwdata[FREQ_W-1:0];
            if (done_acc && pwrite && hit_pins) pins_ff <= pwdata[PIN_W-1:0];
        end
    end

    // serial sequencer: data set while clock low, device samples on the rise
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= HS_IDLE;
            op_ff <= PSCR_OP_PRIMARY;
            bit_ff <= '0;
            tmr_ff <= '0;
            sclk_ff <= 1'b0;
            sdat_ff <= 1'b0;
            xlat_ff <= 1'b0;
            route_ff <= 1'b0;
            copy_ff <= 1'b0;
            capt_ff <= '0;
        end else begin
            tmr_ff <= (st_ff == HS_IDLE || tmr_end) ? 8'h00 : tmr_ff + 8'h01;
            case (st_ff)
                HS_IDLE: begin
                    if (go) begin
                        op_ff <= pscr_op_e'(pwdata[1:0]);
                        bit_ff <= '0;
                        sdat_ff <= data_ff[0]; // [R2]
                        xlat_ff <= pwdata[1:0] == PSCR_OP_TESTMODE; // [R3]
                        route_ff <= pwdata[1:0] == PSCR_OP_MIRROR; // [R3]
                        copy_ff <= pwdata[1:0] == PSCR_OP_COPY; // [R7]
                        st_ff <= (pwdata[1:0] == PSCR_OP_COPY) ? HS_COPY : HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (tmr_end) begin
                        capt_ff <= {rd_sync_ff, capt_ff[FREQ_W-1:1]}; // [R11]
                        sclk_ff <= 1'b1; // [R1]
                        st_ff <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (tmr_end) begin
                        sclk_ff <= 1'b0;
                        bit_ff <= bit_ff + 5'h01;
                        sdat_ff <= last_bit ? 1'b0 : data_ff[bit_ff + 5'h01]; // [R2]
                        st_ff <= last_bit ? HS_DONE : HS_LOW;
                    end
                end
                HS_DONE: begin
                    xlat_ff <= 1'b0; // [R15]
                    route_ff <= 1'b0;
                    if (tmr_end) st_ff <= HS_IDLE;
                end
                HS_COPY: begin
                    if (tmr_end) begin
                        copy_ff <= 1'b0;
                        st_ff <= HS_DONE;
                    end
                end
                default: st_ff <= HS_IDLE;
            endcase
        end
    end

    // readout pin is asynchronous to core_clk
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_meta_ff <= 1'b0;
            rd_sync_ff <= 1'b0;
        end else begin
            rd_meta_ff <= link.readout;
            rd_sync_ff <= rd_meta_ff;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign link.ser_clk = sclk_ff;
    assign link.ser_data = sdat_ff;
    assign link.extra_latch = xlat_ff;
    assign link.route_select = route_ff | pins_ff[PIN_ROUTE];
    assign link.copy_strobe = copy_ff | pins_ff[PIN_COPY];
    assign link.memory_select = pins_ff[PIN_MODULUS_CHOICE];
    assign link.freq_reg_choice = pins_ff[PIN_CHOICE];
    assign link.extra_modes_gate_n = pins_ff[PIN_GATE_N]; // [R13]
endmodule

/* test/pscr_link_assertions.sv */
`timescale 1ns/1ps
// watches the serial link between the host end and the device end
module pscr_link_assertions #(
    parameter int HALF_CYC = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic copy_strobe,
    input wire logic extra_latch,
    input wire logic route_select,
    input wire logic memory_select,
    input wire logic freq_reg_choice,
    input wire logic extra_modes_gate_n,
    input wire logic readout
);
    localparam logic [7:0] HALF = 8'(HALF_CYC);
    logic clk_q_ff;
    logic [7:0] run_ff;
    logic [4:0] bits_ff;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // cycles spent at the present clock level (saturating), and rises counted inside a test or mirror frame
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clk_q_ff <= 1'b0;
            run_ff <= 8'h00;
            bits_ff <= 5'h00;
        end else begin
            clk_q_ff <= ser_clk;
            run_ff <= (ser_clk != clk_q_ff) ? 8'h01 : run_ff + {7'h00, ~&run_ff};
            bits_ff <= (!extra_latch && !route_select) ? 5'h00 : bits_ff + {4'h0, ser_clk & ~clk_q_ff};
        end
    end
    // a copy pulse is one full half period wide; the link rests after a test word
    sequence s_copy_hi;
        copy_strobe [*8] ##1 !copy_strobe;
    endsequence
    sequence s_idle8;
        !ser_clk [*8];
    endsequence
    a_clk_high_len: assert property ($fell(ser_clk) |-> run_ff == HALF) else $error("clock high phase length wrong");
    a_clk_low_len: assert property ($rose(ser_clk) |-> run_ff >= HALF) else $error("clock low phase too short");
    a_data_held: assert property (ser_clk |-> $stable(ser_data)) else $error("data moved while clock high");
    a_dest_excl: assert property (!(extra_latch && route_select)) else $error("two destinations at once");
    a_test_bits: assert property ($fell(extra_latch) |-> bits_ff == 5'h08) else $error("test word not 8 bits");
    a_mirror_bits: assert property ($fell(route_select) |-> bits_ff == 5'h14) else $error("mirror word not 20 bits");
    a_latch_rest: assert property ($fell(extra_latch) |-> s_idle8) else $error("clock moved after latch");
    a_copy_pulse: assert property ($rose(copy_strobe) |-> s_copy_hi) else $error("copy pulse width wrong");
    a_copy_quiet: assert property ($rose(copy_strobe) |-> !extra_latch && !route_select) else $error("copy in frame");
    a_gate_quiet: assert property (extra_modes_gate_n [*4] |-> !readout) else $error("readout with gate high");
endmodule

/* test/tb_pll_serial_control_registers.sv */
`timescale 1ns/1ps
module tb_pll_serial_control_registers;
    import pscr_pkg::*;
    localparam logic [FREQ_W-1:0] NV_WORD = 20'h5A3C1;
    localparam logic [32:0] ALL = {33{1'b1}};
    typedef struct {string name; logic [32:0] exp; logic [32:0] mask;} pscr_exp_s;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, ref_tick, vco_tick, up_n, dn_n, quiet;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] w1, w2, w3;
    logic [REF_W-1:0] ref_value;
    logic [MAIN_W-1:0] main_value;
    logic [SWAL_W-1:0] swallow_value;
    logic prescaler_bypass, power_down, lock_integrate_node, lock_indicator;
    int fail_count, compares;
    pscr_exp_s q[$];
    event snap_ev;
    pscr_link_if link();
    pscr_host u_pscr_host (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link(link));
    pscr_device #(.NV_INIT(NV_WORD)) u_pscr_device (.core_clk, .resetn, .link(link), .ref_tick, .vco_tick,
        .nv_write_pulse(1'b0), .nv_erase_pulse(1'b0), .pump_up_pulse_n(up_n), .pump_down_pulse_n(dn_n),
        .ref_value, .main_value, .swallow_value, .prescaler_bypass, .power_down, .ref_out(), .main_out(),
        .modulus_choice(), .lock_integrate_node, .lock_indicator);
    pscr_link_assertions u_chk (.core_clk, .resetn, .ser_clk(link.ser_clk), .ser_data(link.ser_data),
        .copy_strobe(link.copy_strobe), .extra_latch(link.extra_latch), .route_select(link.route_select),
        .memory_select(link.memory_select), .freq_reg_choice(link.freq_reg_choice),
        .extra_modes_gate_n(link.extra_modes_gate_n), .readout(link.readout));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // random input events keep the divider chains cycling
    always @(posedge core_clk) begin
        ref_tick <= 1'($urandom_range(1));
        vco_tick <= 1'($urandom_range(1));
    end
    // expected outputs, worked out from the shift-order field layout
    function automatic logic [32:0] dv(input logic [19:0] w, input logic pd, input logic u, input logic d);
        return {10'h000, u & d, ~(u & d), pd, w[4], w[16], w[17], w[18], w[19], w[2], w[3], w[5], w[6], w[7],
            w[8], w[9], w[10], w[11], w[0], w[1], w[12], w[13], w[14], w[15]};
    endfunction
    task take(input logic [32:0] v);
        pscr_exp_s e;
        e = q.pop_front();
        compares++;
        if ((v & e.mask) !== (e.exp & e.mask)) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", e.name, e.exp & e.mask, v & e.mask);
        end
    endtask
    // results are judged in issue order; status polls are skipped
    always @(posedge core_clk) if (psel && penable && pready === 1'b1 && !pwrite && !quiet) take({pslverr, prdata});
    always @(snap_ev) take({10'h000, lock_indicator, lock_integrate_node, power_down, prescaler_bypass,
        swallow_value, main_value, ref_value});
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input string n, input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        q.push_back('{n, e, m});
        apb(1'b0, a, 32'h00000000);
    endtask
    // pin changes need the sync chain plus the output stage to land
    task snap(input logic [32:0] e);
        repeat (8) @(posedge core_clk);
        q.push_back('{"device", e, ALL});
        ->snap_ev;
    endtask
    task shift(input pscr_op_e op, input logic [19:0] w);
        apb(1'b1, HOST_DATA_OFS, {12'h000, w});
        apb(1'b1, HOST_CMD_OFS, {30'h00000000, op});
        quiet <= 1'b1;
        do apb(1'b0, HOST_STAT_OFS, 32'h00000000); while (rd[0] !== 1'b0);
        quiet <= 1'b0;
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, quiet, resetn} = 5'h00;
        {up_n, dn_n} = 2'h3;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        fail_count = 0;
        compares = 0;
        void'($urandom(32'h1D7E));
        w1 = 20'($urandom);
        w2 = 20'($urandom);
        w3 = 20'($urandom);
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk("pins", HOST_PINS_OFS, {28'h0000000, PINS_RST}, ALL);
        snap(dv(20'h00000, 1'b0, 1'b1, 1'b1));
        $display("test reset done");
        shift(PSCR_OP_TESTMODE, 20'h00010);
        apb(1'b1, HOST_PINS_OFS, 32'h00000002);
        shift(PSCR_OP_PRIMARY, w1);
        snap(dv(w1, 1'b0, 1'b1, 1'b1));
        $display("test primary done");
        shift(PSCR_OP_COPY, w1);
        apb(1'b1, HOST_PINS_OFS, 32'h00000000);
        shift(PSCR_OP_PRIMARY, w2);
        snap(dv(w1, 1'b0, 1'b1, 1'b1));
        apb(1'b1, HOST_PINS_OFS, 32'h00000002);
        snap(dv(w2, 1'b0, 1'b1, 1'b1));
        $display("test secondary done");
        apb(1'b1, HOST_PINS_OFS, 32'h00000001);
        snap(dv(NV_WORD, 1'b0, 1'b1, 1'b1));
        shift(PSCR_OP_TESTMODE, 20'h00012);
        shift(PSCR_OP_MIRROR, w3);
        rd_chk("capture", HOST_CAPT_OFS, {13'h0000, NV_WORD}, ALL);
        snap(dv(NV_WORD, 1'b0, 1'b1, 1'b1));
        $display("test mirror done");
        apb(1'b1, HOST_PINS_OFS, 32'h00000005);
        snap(dv(NV_WORD, 1'b0, 1'b1, 1'b1));
        apb(1'b1, HOST_PINS_OFS, 32'h00000001);
        shift(PSCR_OP_TESTMODE, 20'h00018);
        snap(dv(NV_WORD, 1'b1, 1'b1, 1'b1));
        apb(1'b1, HOST_PINS_OFS, 32'h00000005);
        snap(dv(NV_WORD, 1'b0, 1'b1, 1'b1));
        $display("test power done");
        for (int i = 0; i < 4; i++) begin
            up_n <= i[1];
            dn_n <= i[0];
            snap(dv(NV_WORD, 1'b0, i[1], i[0]));
        end
        $display("test lock done");
        rd_chk("unmapped", 8'h14, 33'h100000000, 33'h100000000);
        $display("test refusal done");
        complete_run;
    end
    // generous bound: a full run needs well under a tenth of this
    initial begin
        #500000;
        fail_count++;
        complete_run;
    end
endmodule
